/* File: async_parallel_config_handshake.sv */
// Purpose: Device-side control of byte-wide asynchronous parallel configuration loading.
// Assumes: All pins are synchronous to clk; strobes are sampled, not used as clocks.
// Notes:   Two-way bit seven is split into in, out and output enable; open-drain pins into out and output enable.

module async_parallel_config_handshake import cfg_load_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Scheme select and restart
  input  wire logic       async_parallel_load,
  input  wire logic       config_restart_n,
  // Host strobes and selects
  input  wire logic       chip_select_low,
  input  wire logic       chip_select_high,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  // Data bus, bit seven is two-way
  input  wire logic [7:0] data_in,
  output logic            data_bit_seven_out,
  output logic            data_bit_seven_oe,
  // Ready / busy pin
  output logic            ready_not_busy,
  output logic            ready_not_busy_oe,
  input  wire logic       dual_purpose_user_out,
  input  wire logic       dual_purpose_user_oe,
  // Optional pins
  input  wire logic       user_startup_clock,
  output logic            init_done_out,
  output logic            init_done_oe,
  input  wire logic       global_output_enable,
  input  wire logic       global_register_clear_n,
  // Device-wide effects and status
  output logic            io_force_tristate,
  output logic            user_regs_clear,
  output logic            optional_pins_user_io,
  output logic            user_mode,
  output logic            load_error
);

  load_state_t state_q;
  load_state_t state_d;
  options_t    opt_q;
  logic        ws_n_q;
  logic        busy_q;
  logic [7:0]  proc_cnt_q;
  logic [23:0] byte_cnt_q;
  logic [7:0]  init_cnt_q;
  logic        uclk_q;
  logic        rdy_q;
  logic        rdy_oe_q;
  logic        d7_out_q;
  logic        d7_oe_q;
  logic        done_oe_q;
  logic        force_tri_q;
  logic        clr_q;
  logic        opt_io_q;
  logic        user_q;
  logic        err_q;

  // Decoding
  wire selected    = !chip_select_low && chip_select_high;
  wire ws_rise     = !ws_n_q && write_strobe_n;
  wire loading     = (state_q == ST_LOAD);
  wire capture     = loading && selected && ws_rise;
  wire fifo_in_rdy;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire take_byte   = fifo_valid && !busy_q && loading;
  wire proc_done   = busy_q && (proc_cnt_q == 8'(BYTE_PROC_CYC - 1));
  wire first_byte  = take_byte && (byte_cnt_q == 24'h000000);
  wire last_byte   = proc_done && (byte_cnt_q == IMAGE_BYTES);
  wire uclk_tick   = user_startup_clock && !uclk_q;
  wire init_step   = opt_q.user_clk ? uclk_tick : 1'b1;
  wire init_fin    = (state_q == ST_INIT) && init_step && (init_cnt_q == INIT_TICKS - 8'h01);
  // Busy from capture until the byte is consumed; a full FIFO also holds busy
  wire rdy_level   = !(busy_q || fifo_valid || capture || !fifo_in_rdy);
  wire in_config   = (state_q != ST_USER);
  wire done_pull   = config_restart_n && opt_q.done_out && !init_fin
                     && (loading || (state_q == ST_INIT));
  // All options off: optional pins stay weakly pulled user I/O
  wire no_options  = (opt_q == options_t'(OPT_RESET));
  wire force_tri_d = (state_q == ST_USER) && opt_q.glob_oe
                     && !global_output_enable;
  wire clr_d       = (state_q == ST_USER) && opt_q.glob_clr
                     && !global_register_clear_n;
  wire overrun     = ws_rise && loading && selected && !rdy_q;

  byte_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clear     (!config_restart_n),
    .in_valid  (capture),
    .in_ready  (fifo_in_rdy),
    .in_data   (data_in),
    .out_valid (fifo_valid),
    .out_ready (take_byte),
    .out_data  (fifo_data)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (async_parallel_load && selected) state_d = ST_LOAD;
      ST_LOAD: if (last_byte) state_d = ST_INIT;
      ST_INIT: if (init_fin) state_d = ST_USER;
      ST_USER: state_d = ST_USER;
    endcase
  end

  // Restart returns the whole loader to idle
  always_ff @(posedge clk) begin
    if (!reset_n || !config_restart_n) begin
      state_q    <= ST_IDLE;
      opt_q      <= OPT_RESET;
      busy_q     <= 1'b0;
      proc_cnt_q <= 8'h00;
      byte_cnt_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      if (first_byte) begin
        opt_q.done_out <= fifo_data[OPT_DONE_BIT];
        opt_q.user_clk <= fifo_data[OPT_USRCLK_BIT];
        opt_q.glob_oe  <= fifo_data[OPT_OE_BIT];
        opt_q.glob_clr <= fifo_data[OPT_CLR_BIT];
      end
      if (take_byte) begin
        busy_q     <= 1'b1;
        proc_cnt_q <= 8'h00;
        byte_cnt_q <= byte_cnt_q + 24'h000001;
      end else if (proc_done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        proc_cnt_q <= proc_cnt_q + 8'h01;
      end
    end
  end

  // Initialization pacing counter
  always_ff @(posedge clk) begin
    if (!reset_n || !config_restart_n) begin
      init_cnt_q <= 8'h00;
    end else if ((state_q == ST_INIT) && init_step) begin
      init_cnt_q <= init_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ws_n_q <= 1'b1;
      uclk_q <= 1'b0;
    end else begin
      ws_n_q <= write_strobe_n;
      uclk_q <= user_startup_clock;
    end
  end

  // Ready pin: load status while configuring, user drive afterwards
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdy_q    <= 1'b1;
      rdy_oe_q <= 1'b0;
    end else if (in_config && async_parallel_load) begin
      rdy_q    <= (state_q == ST_LOAD) ? rdy_level : 1'b1;
      rdy_oe_q <= 1'b1;
    end else begin
      rdy_q    <= dual_purpose_user_out;
      rdy_oe_q <= dual_purpose_user_oe;
    end
  end

  // Bit seven carries the same status only while the host reads
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      d7_out_q <= 1'b0;
      d7_oe_q  <= 1'b0;
    end else begin
      d7_out_q <= (state_q == ST_LOAD) ? rdy_level : 1'b1;
      d7_oe_q  <= in_config && async_parallel_load && !read_strobe_n;
    end
  end

  // Open drain: low only while enabled and not yet in user operation
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_oe_q <= 1'b0;
    end else begin
      done_oe_q <= done_pull;
    end
  end

  // Device-wide effects; restart drops user mode at once
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opt_io_q    <= 1'b1;
      force_tri_q <= 1'b0;
      clr_q       <= 1'b0;
      user_q      <= 1'b0;
    end else begin
      opt_io_q    <= no_options;
      force_tri_q <= force_tri_d;
      clr_q       <= clr_d;
      user_q      <= config_restart_n && (state_d == ST_USER);
    end
  end

  // Strobe while not ready is a host protocol fault, kept sticky
  always_ff @(posedge clk) begin
    if (!reset_n || !config_restart_n) begin
      err_q <= 1'b0;
    end else if (overrun) begin
      err_q <= 1'b1;
    end
  end

  assign ready_not_busy        = rdy_q;
  assign ready_not_busy_oe     = rdy_oe_q;
  assign data_bit_seven_out    = d7_out_q;
  assign data_bit_seven_oe     = d7_oe_q;
  assign init_done_out         = 1'b0;
  assign init_done_oe          = done_oe_q;
  assign io_force_tristate     = force_tri_q;
  assign user_regs_clear       = clr_q;
  assign optional_pins_user_io = opt_io_q;
  assign user_mode             = user_q;
  assign load_error            = err_q;

endmodule : async_parallel_config_handshake

// Flip-flop FIFO; fill-side ready is honest, and a capture while full is dropped
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || clear) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : byte_fifo

/* File: cfg_load_pkg.sv */
// Purpose: Shared constants and carrier types for the parallel configuration loader.
// Assumes: Single 50 MHz clock, all pins sampled synchronously.
// Notes:   Option bit positions refer to the first configuration frame byte.
package cfg_load_pkg;

  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned FIFO_DEPTH       = 32;
  // Internal processing time per byte, in ns, and its cycle count
  localparam int unsigned BYTE_PROC_NS     = 100;
  localparam int unsigned BYTE_PROC_CYC    = (BYTE_PROC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Bytes in the whole configuration image (plain default)
  localparam logic [23:0] IMAGE_BYTES      = 24'h000040;
  // Start-up clock ticks needed to finish initialization
  localparam logic [7:0]  INIT_TICKS       = 8'h10;
  // Option bits carried in the first frame byte
  localparam int unsigned OPT_DONE_BIT     = 0;
  localparam int unsigned OPT_USRCLK_BIT   = 1;
  localparam int unsigned OPT_OE_BIT       = 2;
  localparam int unsigned OPT_CLR_BIT      = 3;
  localparam logic [3:0]  OPT_RESET        = 4'h0;

  typedef struct packed {
    logic done_out;
    logic user_clk;
    logic glob_oe;
    logic glob_clr;
  } options_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_INIT,
    ST_USER
  } load_state_t;

endpackage : cfg_load_pkg

/* File: byte_fifo.sv */
// Purpose: Holds no logic of its own; the byte FIFO sits beside the loader top.
// Assumes: The loader file is read by every flow that reads this one.
// Notes:   Keeping the FIFO in the loader top's file keeps the loader self-contained.

/* File: cfg_handshake_properties.sv */
// Purpose: Concurrent checks on the loader pins.
// Assumes: One clock, reset_n synchronous and active low.
// Notes:   Bound to the loader top; watches its ports only.
module cfg_handshake_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host side
  input wire logic async_parallel_load,
  input wire logic config_restart_n,
  input wire logic chip_select_low,
  input wire logic chip_select_high,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic dual_purpose_user_oe,
  input wire logic global_output_enable,
  input wire logic global_register_clear_n,
  // Loader outputs
  input wire logic data_bit_seven_oe,
  input wire logic ready_not_busy,
  input wire logic ready_not_busy_oe,
  input wire logic init_done_oe,
  input wire logic io_force_tristate,
  input wire logic user_regs_clear,
  input wire logic user_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire sel = !chip_select_low && chip_select_high;
  wire cfg = async_parallel_load && config_restart_n && !user_mode;

  property p_cfg_drive;
    $past(reset_n) && $past(cfg) && cfg |-> ready_not_busy_oe;
  endproperty
  a_cfg_drive: assert property (p_cfg_drive) else $error("ready pin idle in load");
  property p_busy_after_write;
    $rose(write_strobe_n) && sel && cfg && ready_not_busy |-> ##[1:3] !ready_not_busy;
  endproperty
  a_busy_after_write: assert property (p_busy_after_write) else $error("no busy");
  property p_busy_holds;
    $fell(ready_not_busy) && cfg |-> !ready_not_busy [*5];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy too short");
  property p_ready_returns;
    $fell(ready_not_busy) && cfg |-> ##[1:400] ready_not_busy;
  endproperty
  a_ready_returns: assert property (p_ready_returns) else $error("stuck busy");
  property p_status_release;
    $past(read_strobe_n) |-> !data_bit_seven_oe;
  endproperty
  a_status_release: assert property (p_status_release) else $error("bit seven held");
  property p_restart_done;
    !config_restart_n |=> !init_done_oe;
  endproperty
  a_restart_done: assert property (p_restart_done) else $error("done pin pulled");
  property p_done_to_user;
    $fell(init_done_oe) && config_restart_n && $past(config_restart_n) |-> ##[0:1] user_mode;
  endproperty
  a_done_to_user: assert property (p_done_to_user) else $error("no user mode");
  property p_user_pin;
    user_mode && $past(user_mode) |-> ready_not_busy_oe == $past(dual_purpose_user_oe);
  endproperty
  a_user_pin: assert property (p_user_pin) else $error("pin not user owned");
  property p_tristate;
    $past(global_output_enable) |-> !io_force_tristate;
  endproperty
  a_tristate: assert property (p_tristate) else $error("tristate forced");
  property p_clear;
    $past(global_register_clear_n) |-> !user_regs_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear forced");
endmodule : cfg_handshake_checker

bind async_parallel_config_handshake cfg_handshake_checker i_cfg_handshake_checker (
  .clk(clk), .reset_n(reset_n), .async_parallel_load(async_parallel_load),
  .config_restart_n(config_restart_n), .chip_select_low(chip_select_low),
  .chip_select_high(chip_select_high), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .dual_purpose_user_oe(dual_purpose_user_oe),
  .global_output_enable(global_output_enable),
  .global_register_clear_n(global_register_clear_n),
  .data_bit_seven_oe(data_bit_seven_oe), .ready_not_busy(ready_not_busy),
  .ready_not_busy_oe(ready_not_busy_oe), .init_done_oe(init_done_oe),
  .io_force_tristate(io_force_tristate), .user_regs_clear(user_regs_clear),
  .user_mode(user_mode));

/* File: cfg_host_model.sv */
// Purpose: Host that strobes bytes into the loader and polls ready.
// Assumes: Pins change at the falling edge of clk.
// Notes:   Released data lines show the inverse, never a stale byte.
module cfg_host_model (
  // Clock
  input wire logic  clk,
  // Strobes and data
  output logic       write_strobe_n,
  output logic       read_strobe_n,
  output logic [7:0] data_in,
  // From the loader
  input wire logic  ready_not_busy,
  input wire logic  data_bit_seven_out,
  input wire logic  data_bit_seven_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] data_q = 8'hA5;
  initial write_strobe_n = 1'b1;
  initial read_strobe_n = 1'b1;
  // Bit seven belongs to the loader while it drives
  assign data_in = {data_bit_seven_oe ? data_bit_seven_out : data_q[7], data_q[6:0]};

  task automatic write_byte(input logic [7:0] b, input bit pace);
    int n;
    n = 0;
    while (pace && ready_not_busy !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    data_q = b;
    write_strobe_n = 1'b0;
    @(negedge clk);
    write_strobe_n = 1'b1;
    @(negedge clk);
    data_q = ~b;
    repeat (2) @(negedge clk);
  endtask : write_byte

  task automatic read_status(output logic v);
    read_strobe_n = 1'b0;
    repeat (2) @(negedge clk);
    v = data_in[7];
    read_strobe_n = 1'b1;
  endtask : read_status
endmodule : cfg_host_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the parallel configuration loader.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Image length and init ticks come from the package.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cfg_load_pkg::*;
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected %s exp=%h got=%h", nm, exp, got); end end
  logic clk = 0, reset_n = 0, async_parallel_load = 1, config_restart_n = 1;
  logic chip_select_low = 1, chip_select_high = 0, dual_purpose_user_out = 1;
  logic dual_purpose_user_oe = 1, user_startup_clock = 0, global_output_enable = 1;
  logic global_register_clear_n = 1, write_strobe_n, read_strobe_n, v;
  logic [7:0] data_in;
  logic data_bit_seven_out, data_bit_seven_oe, ready_not_busy, ready_not_busy_oe;
  logic init_done_out, init_done_oe, io_force_tristate, user_regs_clear;
  logic optional_pins_user_io, user_mode, load_error;
  int num_errors = 0, check_count = 0, cycles = 0;

  async_parallel_config_handshake i_async_parallel_config_handshake (.clk(clk),
    .reset_n(reset_n), .async_parallel_load(async_parallel_load),
    .config_restart_n(config_restart_n), .chip_select_low(chip_select_low),
    .chip_select_high(chip_select_high), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .data_in(data_in), .data_bit_seven_out(data_bit_seven_out),
    .data_bit_seven_oe(data_bit_seven_oe), .ready_not_busy(ready_not_busy),
    .ready_not_busy_oe(ready_not_busy_oe), .dual_purpose_user_out(dual_purpose_user_out),
    .dual_purpose_user_oe(dual_purpose_user_oe), .user_startup_clock(user_startup_clock),
    .init_done_out(init_done_out), .init_done_oe(init_done_oe),
    .global_output_enable(global_output_enable),
    .global_register_clear_n(global_register_clear_n), .io_force_tristate(io_force_tristate),
    .user_regs_clear(user_regs_clear), .optional_pins_user_io(optional_pins_user_io),
    .user_mode(user_mode), .load_error(load_error));
  cfg_host_model i_cfg_host_model (.clk(clk), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .data_in(data_in), .ready_not_busy(ready_not_busy),
    .data_bit_seven_out(data_bit_seven_out), .data_bit_seven_oe(data_bit_seven_oe));

  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wait_ready;
    for (int n = 0; n < 400 && ready_not_busy !== 1'b1; n++) tick(1);
  endtask : wait_ready
  task automatic t_unselected;
    logic [1:0] cs [3] = '{2'b00, 2'b11, 2'b10};
    foreach (cs[i]) begin
      {chip_select_low, chip_select_high} = cs[i];
      tick(2);
      i_cfg_host_model.write_byte(8'h0F, 1'b0);
      `CHK("ready_unsel", 1'b1, ready_not_busy)
      `CHK("err_unsel", 1'b0, load_error)
    end
  endtask : t_unselected
  task automatic t_load;
    chip_select_low = 1'b0;
    chip_select_high = 1'b1;
    tick(2);
    `CHK("done_pre", 1'b0, init_done_oe)
    `CHK("done_out", 1'b0, init_done_out)
    i_cfg_host_model.write_byte(8'h0F, 1'b1);
    `CHK("busy", 1'b0, ready_not_busy)
    i_cfg_host_model.read_status(v);
    `CHK("bit7_busy", 1'b0, v)
    wait_ready();
    `CHK("done_low", 1'b1, init_done_oe)
    `CHK("opt_pins", 1'b0, optional_pins_user_io)
    for (int i = 1; i < IMAGE_BYTES; i++) i_cfg_host_model.write_byte(8'(i), 1'b1);
    wait_ready();
    `CHK("ready_post", 1'b1, ready_not_busy)
    repeat (int'(INIT_TICKS) - 1) begin
      user_startup_clock = 1'b1;
      tick(2);
      user_startup_clock = 1'b0;
      tick(2);
    end
    `CHK("user_early", 1'b0, user_mode)
    user_startup_clock = 1'b1;
    tick(2);
    user_startup_clock = 1'b0;
    for (int n = 0; n < 20 && init_done_oe !== 1'b0; n++) tick(1);
    `CHK("user_mode", 1'b1, user_mode)
    `CHK("done_rel", 1'b0, init_done_oe)
    dual_purpose_user_oe = 1'b0;
    tick(2);
    `CHK("pin_user_oe", 1'b0, ready_not_busy_oe)
  endtask : t_load
  task automatic t_globals;
    global_output_enable = 1'b0;
    tick(2);
    `CHK("tristate", 1'b1, io_force_tristate)
    global_output_enable = 1'b1;
    global_register_clear_n = 1'b0;
    tick(2);
    `CHK("clear", 1'b1, user_regs_clear)
    `CHK("tristate_off", 1'b0, io_force_tristate)
    global_register_clear_n = 1'b1;
  endtask : t_globals
  task automatic t_restart_error;
    config_restart_n = 1'b0;
    tick(2);
    `CHK("done_rst", 1'b0, init_done_oe)
    `CHK("user_rst", 1'b0, user_mode)
    config_restart_n = 1'b1;
    tick(2);
    i_cfg_host_model.write_byte(8'h00, 1'b1);
    i_cfg_host_model.write_byte(8'hFF, 1'b0);
    tick(1);
    `CHK("overrun", 1'b1, load_error)
    wait_ready();
    `CHK("opt_off", 1'b1, optional_pins_user_io)
  endtask : t_restart_error
  task automatic results;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    tick(4);
    `CHK("ready_rst", 1'b1, ready_not_busy)
    `CHK("opt_rst", 1'b1, optional_pins_user_io)
    reset_n = 1'b1;
    tick(2);
    t_unselected();
    t_load();
    t_globals();
    t_restart_error();
    results();
  end
endmodule : testbench
